// >>> rtl/gpp_pkg.sv
// Package for the eight-pin general purpose port.
// Assumes an APB slave with 32-bit data and one register per word.
`default_nettype none
package gpp_pkg;
    localparam int          GPP_WIDTH         = 8;
    localparam logic [11:0] GPP_OFF_PIN_DATA  = 12'h000;
    localparam logic [11:0] GPP_OFF_LATCH     = 12'h004;
    localparam logic [11:0] GPP_OFF_DIR       = 12'h008;
    localparam logic [11:0] GPP_OFF_ANALOG    = 12'h00c;
    localparam logic [11:0] GPP_OFF_PULLUP    = 12'h010;
    localparam logic [11:0] GPP_OFF_THRESH    = 12'h014;
    localparam logic [11:0] GPP_OFF_SLEW      = 12'h018;
    localparam logic [11:0] GPP_OFF_ODRAIN    = 12'h01c;
    localparam logic [7:0]  GPP_RST_LATCH     = 8'h00;
    localparam logic [7:0]  GPP_RST_DIR       = 8'hff;
    localparam logic [7:0]  GPP_RST_ANALOG    = 8'hff;
    localparam logic [7:0]  GPP_RST_PULLUP    = 8'h00;
    localparam logic [7:0]  GPP_RST_THRESH    = 8'h00;
    localparam logic [7:0]  GPP_RST_SLEW      = 8'hff;
    localparam logic [7:0]  GPP_RST_ODRAIN    = 8'h00;

    typedef struct packed {
        logic [7:0] drive;
        logic [7:0] drive_en;
    } gpp_pad_out_t;

    typedef struct packed {
        logic [7:0] open_drain;
        logic [7:0] slew_limit;
        logic [7:0] threshold_ttl;
        logic [7:0] pullup_en;
        logic [7:0] analog_in;
    } gpp_pad_cfg_t;
endpackage : gpp_pkg
`default_nettype wire

// >>> rtl/gpp_port.sv
// Eight-pin general purpose port with APB register access.
// Assumes pins arrive asynchronously; pad cells apply drive and config.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module gpp_port
    import gpp_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clock,
    input  wire logic                 resetn,
    // APB slave.
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // Pins.
    input  wire logic [7:0]           pin_in,
    output logic [7:0]                pin_out,
    output logic [7:0]                pin_oe,
    output gpp_pkg::gpp_pad_cfg_t     pad_cfg,
    // Priority owners of the pins.
    input  wire logic [7:0]           config_own,
    input  wire logic [7:0]           config_out,
    input  wire logic [7:0]           config_oe,
    input  wire logic [7:0]           analog_out_en,
    input  wire logic [7:0]           periph_sel,
    input  wire logic [7:0]           periph_out,
    input  wire logic [7:0]           periph_oe,
    // Digital input levels to peripherals.
    output logic [7:0]                digital_in
);
    import gpp_pkg::*;

    logic [7:0] sync1_reg, sync2_reg;
    logic [7:0] output_latch_reg, output_latch_next;
    logic [7:0] direction_ctrl_reg, direction_ctrl_next;
    logic [7:0] analog_select_reg, analog_select_next;
    logic [7:0] weak_pullup_ctrl_reg, weak_pullup_ctrl_next;
    logic [7:0] input_threshold_sel_reg, input_threshold_sel_next;
    logic [7:0] slew_limit_ctrl_reg, slew_limit_ctrl_next;
    logic [7:0] open_drain_ctrl_reg, open_drain_ctrl_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pslverr_reg, pslverr_next;
    logic        pready_reg, pready_next;
    logic [7:0]  pin_out_reg, pin_out_next;
    logic [7:0]  pin_oe_reg, pin_oe_next;
    logic [7:0]  din_reg, din_next;
    gpp_pad_cfg_t cfg_reg, cfg_next;
    logic [7:0]  port_pin_data;
    logic        wr_acc, rd_acc, hit;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
        end
    end

    assign port_pin_data = sync2_reg & ~analog_select_reg;

    assign wr_acc = psel & penable & pwrite & pready_reg;
    assign rd_acc = psel & ~penable & ~pwrite;
    always_comb begin
        unique case (paddr)
            GPP_OFF_PIN_DATA, GPP_OFF_LATCH, GPP_OFF_DIR, GPP_OFF_ANALOG,
            GPP_OFF_PULLUP, GPP_OFF_THRESH, GPP_OFF_SLEW,
            GPP_OFF_ODRAIN: hit = 1'b1;
            default:        hit = 1'b0;
        endcase
    end

    // Register writes; one bit per pin in byte lane zero.
    always_comb begin
        output_latch_next        = output_latch_reg;
        direction_ctrl_next      = direction_ctrl_reg;
        analog_select_next       = analog_select_reg;
        weak_pullup_ctrl_next    = weak_pullup_ctrl_reg;
        input_threshold_sel_next = input_threshold_sel_reg;
        slew_limit_ctrl_next     = slew_limit_ctrl_reg;
        open_drain_ctrl_next     = open_drain_ctrl_reg;
        if (wr_acc && pstrb[0]) begin
            unique case (paddr)
                GPP_OFF_PIN_DATA, GPP_OFF_LATCH:
                    output_latch_next = pwdata[7:0];
                GPP_OFF_DIR:    direction_ctrl_next      = pwdata[7:0];
                GPP_OFF_ANALOG: analog_select_next       = pwdata[7:0];
                GPP_OFF_PULLUP: weak_pullup_ctrl_next    = pwdata[7:0];
                GPP_OFF_THRESH: input_threshold_sel_next = pwdata[7:0];
                GPP_OFF_SLEW:   slew_limit_ctrl_next     = pwdata[7:0];
                GPP_OFF_ODRAIN: open_drain_ctrl_next     = pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Read data captured in setup, presented in access phase.
    always_comb begin
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        pready_next  = psel & ~penable;
        if (rd_acc) begin
            unique case (paddr)
                // data reads pins, latch reads latch.
                GPP_OFF_PIN_DATA: prdata_next = {24'h0, port_pin_data};
                GPP_OFF_LATCH:    prdata_next = {24'h0, output_latch_reg};
                GPP_OFF_DIR:      prdata_next = {24'h0, direction_ctrl_reg};
                GPP_OFF_ANALOG:   prdata_next = {24'h0, analog_select_reg};
                GPP_OFF_PULLUP:   prdata_next = {24'h0, weak_pullup_ctrl_reg};
                GPP_OFF_THRESH:
                    prdata_next = {24'h0, input_threshold_sel_reg};
                GPP_OFF_SLEW:     prdata_next = {24'h0, slew_limit_ctrl_reg};
                GPP_OFF_ODRAIN:   prdata_next = {24'h0, open_drain_ctrl_reg};
                default:          prdata_next = 32'h0;
            endcase
        end
        if (psel && !penable) begin
            pslverr_next = ~hit;
        end
    end

    // Pin ownership and drivers.
    always_comb begin
        pin_out_next = 8'h00;
        pin_oe_next  = 8'h00;
        for (int i = 0; i < GPP_WIDTH; i++) begin
            if (config_own[i]) begin
                pin_out_next[i] = config_out[i];
                pin_oe_next[i]  = config_oe[i];
            end else if (analog_out_en[i]) begin
                pin_out_next[i] = 1'b0;
                pin_oe_next[i]  = 1'b0;
            end else if (periph_sel[i]) begin
                pin_out_next[i] = periph_out[i];
                pin_oe_next[i]  = periph_oe[i];
            end else begin
                pin_out_next[i] = output_latch_reg[i];
                pin_oe_next[i]  = ~direction_ctrl_reg[i];
            end
            if (open_drain_ctrl_reg[i] && pin_out_next[i]) begin
                pin_oe_next[i] = 1'b0;
            end
        end
        din_next = port_pin_data;
        cfg_next = '{open_drain:    open_drain_ctrl_reg,
                     slew_limit:    slew_limit_ctrl_reg,
                     threshold_ttl: input_threshold_sel_reg,
                     pullup_en:     weak_pullup_ctrl_reg,
                     analog_in:     analog_select_reg};
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            output_latch_reg        <= GPP_RST_LATCH;
            direction_ctrl_reg      <= GPP_RST_DIR;
            analog_select_reg       <= GPP_RST_ANALOG;
            weak_pullup_ctrl_reg    <= GPP_RST_PULLUP;
            input_threshold_sel_reg <= GPP_RST_THRESH;
            slew_limit_ctrl_reg     <= GPP_RST_SLEW;
            open_drain_ctrl_reg     <= GPP_RST_ODRAIN;
            prdata_reg              <= 32'h0;
            pslverr_reg             <= 1'b0;
            pready_reg              <= 1'b0;
            pin_out_reg             <= 8'h00;
            pin_oe_reg              <= 8'h00;
            din_reg                 <= 8'h00;
            cfg_reg                 <= '0;
        end else begin
            output_latch_reg        <= output_latch_next;
            direction_ctrl_reg      <= direction_ctrl_next;
            analog_select_reg       <= analog_select_next;
            weak_pullup_ctrl_reg    <= weak_pullup_ctrl_next;
            input_threshold_sel_reg <= input_threshold_sel_next;
            slew_limit_ctrl_reg     <= slew_limit_ctrl_next;
            open_drain_ctrl_reg     <= open_drain_ctrl_next;
            prdata_reg              <= prdata_next;
            pslverr_reg             <= pslverr_next;
            pready_reg              <= pready_next;
            pin_out_reg             <= pin_out_next;
            pin_oe_reg              <= pin_oe_next;
            din_reg                 <= din_next;
            cfg_reg                 <= cfg_next;
        end
    end

    assign pready     = pready_reg;
    assign prdata     = prdata_reg;
    assign pslverr    = pslverr_reg;
    assign pin_out    = pin_out_reg;
    assign pin_oe     = pin_oe_reg;
    assign digital_in = din_reg;
    assign pad_cfg    = cfg_reg;

    dir_drive_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (~config_own[0] & ~analog_out_en[0] & ~periph_sel[0]
         & ~open_drain_ctrl_reg[0])
        |=> pin_oe[0] == ~$past(direction_ctrl_reg[0]))
        else $error("Pin driver does not follow direction.");
    analog_out_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (~config_own[1] & analog_out_en[1]) |=> !pin_oe[1])
        else $error("Analog output left driver on.");
    analog_read_a: assert property (
        @(posedge clock) disable iff (!resetn)
        analog_select_reg[2] |=> !digital_in[2])
        else $error("Analog pin read nonzero.");
    data_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (wr_acc && pstrb[0] && paddr == GPP_OFF_PIN_DATA)
        |=> output_latch_reg == $past(pwdata[7:0]))
        else $error("Data write missed latch.");
    sync_delay_a: assert property (
        @(posedge clock) disable iff (!resetn)
        $past(resetn) |-> ##2 (sync2_reg == $past(pin_in, 2)))
        else $error("Synchroniser delay wrong.");
    open_drain_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (~config_own[3] & open_drain_ctrl_reg[3])
        |=> !(pin_oe[3] && pin_out[3]))
        else $error("Open drain drove high.");
    periph_own_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (~config_own[4] & ~analog_out_en[4] & periph_sel[4])
        |=> pin_out[4] == $past(periph_out[4]))
        else $error("Peripheral not owning pin.");
    latch_read_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (rd_acc && paddr == GPP_OFF_LATCH)
        |=> prdata[7:0] == $past(output_latch_reg))
        else $error("Latch read wrong.");
    analog_reset_a: assert property (
        @(posedge clock) disable iff (!resetn)
        $rose(resetn) |-> analog_select_reg == GPP_RST_ANALOG)
        else $error("Analog select not set after reset.");
    pin_read_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (rd_acc && paddr == GPP_OFF_PIN_DATA)
        |=> prdata == {24'h0, $past(port_pin_data)})
        else $error("Pin data read wrong.");
    latch_drive_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (~config_own[5] & ~analog_out_en[5] & ~periph_sel[5])
        |=> pin_out[5] == $past(output_latch_reg[5]))
        else $error("Latch does not drive free pin.");
    config_own_a: assert property (
        @(posedge clock) disable iff (!resetn)
        config_own[7] |=> pin_out[7] == $past(config_out[7]))
        else $error("Configuration owner lost the pin.");
    analog_drive_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (analog_select_reg[6] & ~config_own[6] & ~analog_out_en[6]
         & ~periph_sel[6] & ~open_drain_ctrl_reg[6])
        |=> pin_oe[6] == ~$past(direction_ctrl_reg[6]))
        else $error("Analog select changed the driver.");
    latch_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (wr_acc && pstrb[0] && paddr == GPP_OFF_LATCH)
        |=> output_latch_reg == $past(pwdata[7:0]))
        else $error("Latch write missed latch.");
endmodule : gpp_port
`default_nettype wire

// >>> sim/gpp_pin_model.sv
// Pin-side model: resolves each pad from port drive, an outside driver,
// the weak pull-up, or a floating pattern.
// Assumes the port's pad outputs and a bench-controlled outside driver.
`timescale 1ns/100ps
`default_nettype none
module gpp_pin_model
    import gpp_pkg::*;
(
    // Clock.
    input  wire logic                  clock,
    // Port pad side.
    input  wire logic [7:0]            pin_out,
    input  wire logic [7:0]            pin_oe,
    input  wire gpp_pkg::gpp_pad_cfg_t pad_cfg,
    // Outside driver.
    input  wire logic [7:0]            ext_val,
    input  wire logic [7:0]            ext_en,
    // Resolved level.
    output logic [7:0]                 pin_in
);
    logic [7:0] float_reg = 8'h55;
    // A floating pin shows a changing pattern, never its last value.
    always @(posedge clock) begin
        float_reg <= ~float_reg;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pad_cfg.pullup_en[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = float_reg[i];
        end
    end
endmodule : gpp_pin_model
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the eight-pin port.
// Assumes gpp_port and gpp_pin_model; APB master is this bench.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import gpp_pkg::*;
    logic         clock, resetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata;
    logic [3:0]   pstrb;
    logic [7:0]   pin_in, pin_out, pin_oe, digital_in, ext_val, ext_en;
    logic [7:0]   c_own, c_out, c_oe, an_out, p_sel, p_out, p_oe;
    gpp_pad_cfg_t pad_cfg;
    int           miscompares, compares, cycles;

    gpp_port i_gpp_port (.clock(clock), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pad_cfg(pad_cfg), .config_own(c_own), .config_out(c_out),
        .config_oe(c_oe), .analog_out_en(an_out), .periph_sel(p_sel),
        .periph_out(p_out), .periph_oe(p_oe), .digital_in(digital_in));
    gpp_pin_model i_gpp_pin_model (.clock(clock), .pin_out(pin_out),
        .pin_oe(pin_oe), .pad_cfg(pad_cfg), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));

    always #2.5 clock = ~clock;

    task report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
             output logic [31:0] rd, output logic er);
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
    endtask : wr

    task look(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : look

    task chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t pins %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task chk_rd(input logic [11:0] a, input logic [7:0] e, input logic ee);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 8'h00, rd, er);
        compares++;
        if (rd !== {24'h0, e} || er !== ee) begin
            miscompares++;
            $display("ERROR %0t read %h gave %h err %b", $time, a, rd, er);
        end
    endtask : chk_rd

    task t_reset;
        look(2);
        chk8(pin_oe, 8'h00);
        chk8(pad_cfg.analog_in, GPP_RST_ANALOG);
        chk_rd(GPP_OFF_DIR, GPP_RST_DIR, 1'b0);
        chk_rd(GPP_OFF_ANALOG, GPP_RST_ANALOG, 1'b0);
        chk_rd(GPP_OFF_SLEW, GPP_RST_SLEW, 1'b0);
        chk_rd(GPP_OFF_LATCH, GPP_RST_LATCH, 1'b0);
    endtask : t_reset

    task t_latch;
        wr(GPP_OFF_ANALOG, 8'h00);
        wr(GPP_OFF_LATCH, 8'ha5);
        wr(GPP_OFF_DIR, 8'h00);
        look(2);
        chk8(pin_oe, 8'hff);
        chk8(pin_out, 8'ha5);
        chk_rd(GPP_OFF_PIN_DATA, 8'ha5, 1'b0);
        wr(GPP_OFF_PIN_DATA, 8'h3c);
        chk_rd(GPP_OFF_LATCH, 8'h3c, 1'b0);
        wr(GPP_OFF_LATCH, 8'h81);
        look(3);
        chk_rd(GPP_OFF_PIN_DATA, 8'h81, 1'b0);
        wr(GPP_OFF_ANALOG, 8'hff);
        look(4);
        chk8(pin_out, 8'h81);
        chk8(digital_in, 8'h00);
        chk_rd(GPP_OFF_PIN_DATA, 8'h00, 1'b0);
        wr(GPP_OFF_ANALOG, 8'h00);
    endtask : t_latch

    task t_input;
        ext_val <= 8'h5a;
        ext_en  <= 8'hff;
        wr(GPP_OFF_DIR, 8'hff);
        look(5);
        chk_rd(GPP_OFF_PIN_DATA, 8'h5a, 1'b0);
        chk_rd(GPP_OFF_LATCH, 8'h81, 1'b0);
        @(posedge clock);
        ext_val <= 8'hc3;
        look(2);
        chk8(digital_in, 8'h5a);
        look(1);
        chk8(digital_in, 8'hc3);
        @(posedge clock);
        ext_en <= 8'h00;
        wr(GPP_OFF_DIR, 8'h00);
    endtask : t_input

    task t_priority;
        an_out <= 8'h03;
        p_sel  <= 8'h06;
        p_oe   <= 8'h06;
        p_out  <= 8'h04;
        c_own  <= 8'h81;
        c_oe   <= 8'h81;
        c_out  <= 8'h80;
        look(4);
        chk8(pin_oe, 8'hfd);
        chk8(pin_out & pin_oe, 8'h84);
        chk8(digital_in & 8'h04, 8'h04);
        @(posedge clock);
        an_out <= 8'h00;
        p_sel  <= 8'h00;
        c_own  <= 8'h00;
    endtask : t_priority

    task t_config;
        wr(GPP_OFF_ODRAIN, 8'hff);
        wr(GPP_OFF_LATCH, 8'ha5);
        wr(GPP_OFF_SLEW, 8'h0f);
        wr(GPP_OFF_THRESH, 8'h3c);
        wr(GPP_OFF_PULLUP, 8'h99);
        look(2);
        chk8(pin_oe, 8'h5a);
        chk8(pin_out & pin_oe, 8'h00);
        chk8(pad_cfg.slew_limit, 8'h0f);
        chk8(pad_cfg.threshold_ttl, 8'h3c);
        chk8(pad_cfg.pullup_en, 8'h99);
        chk8(pad_cfg.open_drain, 8'hff);
        chk_rd(GPP_OFF_ODRAIN, 8'hff, 1'b0);
        wr(12'h020, 8'h11);
        chk_rd(12'h020, 8'h00, 1'b1);
        pstrb <= 4'h0;
        wr(GPP_OFF_LATCH, 8'h00);
        pstrb <= 4'hf;
        chk_rd(GPP_OFF_LATCH, 8'ha5, 1'b0);
    endtask : t_config

    initial begin
        clock   = 1'b0;
        resetn  = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        pstrb   = 4'hf;
        {ext_val, ext_en, c_own, c_out, c_oe} = 40'h0;
        {an_out, p_sel, p_out, p_oe} = 32'h0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        t_latch();
        t_input();
        t_priority();
        t_config();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
